// ### rtl/ppg_cfg.svh
`ifndef PPG_CFG_SVH
`define PPG_CFG_SVH
// Byte addresses on APB
`define PPG_ADDR_FUNC_CTRL   12'h000
`define PPG_ADDR_OUT_ENABLE  12'h004
`define PPG_ADDR_AUX_CTRL    12'h008
`define PPG_ADDR_STATUS      12'h00c
// Reset values
`define PPG_FUNC_CTRL_RST    8'hc0
`define PPG_OUT_ENABLE_RST   8'hff
`define PPG_AUX_CTRL_RST     8'h01
// Fixed-one reserved bits
`define PPG_RSVD_ONES        8'hc0
`define PPG_RSVD_MASK        8'hc0
// Field positions
`define PPG_MODE_HI_BIT      5
`define PPG_MODE_LO_BIT      4
`define PPG_BUF_MSB          3
`define PPG_OE_MSB           5
`define PPG_XTB_BIT          0
`define PPG_NPINS            6
`endif

// ### rtl/ppg_pkg.sv
package ppg_pkg;
  typedef enum logic [1:0] {
    PPG_NORMAL = 2'b00,
    PPG_COMP   = 2'b01,
    PPG_RSYNC  = 2'b11
  } ppg_mode_t;
endpackage : ppg_pkg

// ### rtl/ppg_pin_gate.sv
`timescale 1ns/1ps
`include "ppg_cfg.svh"
module ppg_pin_gate
  import ppg_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [`PPG_NPINS-1:0]    master_en,
  input  wire logic [`PPG_NPINS-1:0]    timer_out,
  input  wire logic [`PPG_NPINS-1:0]    timer_oe,
  output logic      [`PPG_NPINS-1:0]    pin_out,
  output logic      [`PPG_NPINS-1:0]    pin_timer_sel
);
  // ****************************************
  // Per-pin gating
  // ****************************************
  for (genvar i = 0; i < `PPG_NPINS; i++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_out[i]       <= 1'b0;
        pin_timer_sel[i] <= 1'b0;
      end else begin
        pin_out[i]       <= master_en[i] & timer_out[i];  // [R11] [R12]
        pin_timer_sel[i] <= master_en[i] & timer_oe[i];   // [R11] [R12]
      end
    end
  end
endmodule : ppg_pin_gate

// ### rtl/ppg_top.sv
// Operation
// R1: Function control register loads c0 on reset and on standby entry.
// R2: Bits 7 and 6 of both registers ignore writes and read as one.
// R3: Mode field 5:4: 00/01 normal, 10 complementary PWM, 11 reset-synchronized PWM.
// R4: Software stops the used counters before selecting a combined PWM mode.
// R5: Combined PWM modes override the per-channel PWM select bits of channels 3, 4.
// R6: Channel 3 and 4 sync preset/clear stay valid in combined PWM modes.
// R7: Software never sets both channel sync bits while complementary PWM is on.
// R8: Bits 3..0 enable buffering of ch4 B, ch4 A, ch3 B, ch3 A compares.
// R9: Output master enable register loads ff on reset and on standby entry.
// R10: Enable bits 5..0 gate ch4 comp B, comp A, ch3 B, ch4 B, ch4 A, ch3 A.
// R11: A cleared enable bit suppresses timer output, leaving the pin general-purpose.
// R12: A set enable bit lets the pin carry timer output per the mode settings.
// R13: With trigger block low, channel 1 capture A clears all six enables.
// R14: Trigger block resets to one; trigger acts only in combined PWM modes.
// R15: Complementary PWM makes ch3/ch4 counters count up and down, else up only.
// R16: Hardware trigger clear wins over a coinciding software write.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ppg_cfg.svh"
module ppg_top
  import ppg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        standby_entry,
  input  wire logic        ch1_capture_a,
  input  wire logic        ch3_pulse_width_select,
  input  wire logic        ch4_pulse_width_select,
  input  wire logic        ch3_sync_select,
  input  wire logic        ch4_sync_select,
  input  wire logic [5:0]  timer_out,
  input  wire logic [5:0]  timer_oe,
  output logic [5:0]       pin_out,
  output logic [5:0]       pin_timer_sel,
  output logic             ch3_pwm_eff,
  output logic             ch4_pwm_eff,
  output logic             ch3_sync_eff,
  output logic             ch4_sync_eff,
  output logic             comp_pwm_on,
  output logic             rsync_pwm_on,
  output logic             updown_count,
  output logic [3:0]       buffer_on
);
  // ****************************************
  // Registers and decode
  // ****************************************
  logic [5:0] func_q;
  logic [5:0] oe_q;
  logic       xtb_q;
  logic       trig_seen_q;
  logic       wr_en;
  logic       rd_en;
  logic       hit;
  logic       combined;
  logic       trig_clr;
  logic [5:0] oe_d;
  ppg_mode_t  mode;
  logic       comp_sel;
  logic       rsync_sel;
  logic       wr_func;
  logic       wr_oe;
  logic       wr_aux;
  logic       clr_stat;
  logic [7:0] rd_byte;

  // ****************************************
  // Access strobes
  // ****************************************
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & ~penable & ~pwrite;
  assign wr_func  = wr_en & (paddr == `PPG_ADDR_FUNC_CTRL);
  assign wr_oe    = wr_en & (paddr == `PPG_ADDR_OUT_ENABLE);
  assign wr_aux   = wr_en & (paddr == `PPG_ADDR_AUX_CTRL);
  assign clr_stat = wr_en & (paddr == `PPG_ADDR_STATUS) & pwdata[0];

  // ****************************************
  // Address decode
  // ****************************************
  assign hit   = (paddr == `PPG_ADDR_FUNC_CTRL) | (paddr == `PPG_ADDR_OUT_ENABLE) |
                 (paddr == `PPG_ADDR_AUX_CTRL) | (paddr == `PPG_ADDR_STATUS);

  // ****************************************
  // Mode decode
  // ****************************************
  always_comb begin
    case (func_q[`PPG_MODE_HI_BIT:`PPG_MODE_LO_BIT])  // [R3]
      2'b10:   mode = PPG_COMP;
      2'b11:   mode = PPG_RSYNC;
      default: mode = PPG_NORMAL;
    endcase
  end

  assign combined  = (mode != PPG_NORMAL);
  assign comp_sel  = (mode == PPG_COMP);
  assign rsync_sel = (mode == PPG_RSYNC);

  // ****************************************
  // Output trigger clear
  // ****************************************
  assign trig_clr = ch1_capture_a & ~xtb_q & combined;  // [R13] [R14]

  // ****************************************
  // Function control register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q <= 6'(`PPG_FUNC_CTRL_RST);  // [R1]
    end else if (standby_entry) begin
      func_q <= 6'(`PPG_FUNC_CTRL_RST);  // [R1]
    end else if (wr_func) begin
      func_q <= pwdata[5:0];  // [R2]
    end
  end

  // ****************************************
  // Output master enable register
  // ****************************************
  always_comb begin
    oe_d = oe_q;
    if (wr_oe) begin
      oe_d = pwdata[`PPG_OE_MSB:0];  // [R2]
    end
    if (trig_clr) begin
      oe_d = 6'h00;  // [R13] [R16]
    end
  end

  // ****************************************
  // Output master enable state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= 6'(`PPG_OUT_ENABLE_RST);  // [R9]
    end else if (standby_entry) begin
      oe_q <= 6'(`PPG_OUT_ENABLE_RST);  // [R9]
    end else begin
      oe_q <= oe_d;
    end
  end

  // ****************************************
  // Trigger block bit, set by reset and standby
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtb_q <= 1'b1;  // [R14]
    end else if (standby_entry) begin
      xtb_q <= 1'b1;  // [R14]
    end else if (wr_aux) begin
      xtb_q <= pwdata[`PPG_XTB_BIT];
    end
  end

  // ****************************************
  // Trigger status, set wins over clear
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_seen_q <= 1'b0;
    end else if (standby_entry) begin
      trig_seen_q <= 1'b0;
    end else if (trig_clr) begin
      trig_seen_q <= 1'b1;
    end else if (clr_stat) begin
      trig_seen_q <= 1'b0;
    end
  end

  // ****************************************
  // APB answer, no wait states
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~hit;
    end
  end

  // ****************************************
  // Read data, captured in the setup cycle
  // ****************************************
  always_comb begin
    rd_byte = 8'h00;
    case (paddr)
      `PPG_ADDR_FUNC_CTRL:  rd_byte = `PPG_RSVD_ONES | {2'b00, func_q};  // [R2]
      `PPG_ADDR_OUT_ENABLE: rd_byte = `PPG_RSVD_ONES | {2'b00, oe_q};    // [R2]
      `PPG_ADDR_AUX_CTRL:   rd_byte = {7'h00, xtb_q};
      `PPG_ADDR_STATUS:     rd_byte = {4'h0, combined, comp_sel, 1'b0, trig_seen_q};
      default:              rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= {24'h00_0000, rd_byte};
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // PWM select override
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch3_pwm_eff <= 1'b0;
    end else begin
      ch3_pwm_eff <= ch3_pulse_width_select & ~combined;  // [R5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch4_pwm_eff <= 1'b0;
    end else begin
      ch4_pwm_eff <= ch4_pulse_width_select & ~combined;  // [R5]
    end
  end

  // ****************************************
  // Sync select pass-through
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch3_sync_eff <= 1'b0;
    end else begin
      ch3_sync_eff <= ch3_sync_select;  // [R6]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch4_sync_eff <= 1'b0;
    end else begin
      ch4_sync_eff <= ch4_sync_select;  // [R6]
    end
  end

  // ****************************************
  // Combined mode flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_pwm_on <= 1'b0;
    end else begin
      comp_pwm_on <= comp_sel;  // [R3]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsync_pwm_on <= 1'b0;
    end else begin
      rsync_pwm_on <= rsync_sel;  // [R3]
    end
  end

  // ****************************************
  // Counting direction
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      updown_count <= 1'b0;
    end else begin
      updown_count <= comp_sel;  // [R15]
    end
  end

  // ****************************************
  // Buffer enables
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_on <= 4'h0;
    end else begin
      buffer_on <= func_q[`PPG_BUF_MSB:0];  // [R8]
    end
  end

  // ****************************************
  // Pin gating, bit i of enables to pin i
  // ****************************************
  ppg_pin_gate u_gate (
    .pclk          (pclk),
    .presetn       (presetn),
    .master_en     (oe_q),  // [R10]
    .timer_out     (timer_out),
    .timer_oe      (timer_oe),
    .pin_out       (pin_out),
    .pin_timer_sel (pin_timer_sel)
  );
endmodule : ppg_top

// ### sim/ppg_top_sva.sv
`timescale 1ns/1ps
module ppg_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        standby_entry,
  input wire logic        ch3_pulse_width_select,
  input wire logic        ch3_sync_select,
  input wire logic        ch4_sync_select,
  input wire logic        ch3_pwm_eff,
  input wire logic        ch3_sync_eff,
  input wire logic        ch4_sync_eff,
  input wire logic        comp_pwm_on,
  input wire logic        rsync_pwm_on,
  input wire logic        updown_count,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [5:0]  timer_out,
  input wire logic [5:0]  timer_oe,
  input wire logic [5:0]  pin_out,
  input wire logic [5:0]  pin_timer_sel,
  input wire logic [3:0]  buffer_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_f;
  assign wr_f = psel && penable && pwrite && pready && paddr == 12'h000 && !standby_entry;
  a_rsvd_read: assert property (pready && !pwrite && (paddr == 12'h000 || paddr == 12'h004) |->
    prdata[7:6] == 2'b11 && prdata[31:8] == 24'h000000) else $error("reserved bits wrong");
  a_mode_decode: assert property (wr_f |-> ##2 comp_pwm_on == ($past(pwdata[5:4], 2) == 2'b10) &&
    rsync_pwm_on == ($past(pwdata[5:4], 2) == 2'b11)) else $error("mode decode wrong");
  a_mode_excl: assert property (!(comp_pwm_on && rsync_pwm_on)) else $error("two modes at once");
  a_buf_bits: assert property (wr_f |-> ##2 buffer_on == $past(pwdata[3:0], 2)) else $error("buffer bits");
  a_pwm_ignore: assert property ($past(presetn) |->
    ch3_pwm_eff == ($past(ch3_pulse_width_select) && !comp_pwm_on && !rsync_pwm_on)) else $error("pwm select");
  a_sync_kept: assert property ($past(presetn) |-> ch3_sync_eff == $past(ch3_sync_select) &&
    ch4_sync_eff == $past(ch4_sync_select)) else $error("sync select lost");
  a_count_dir: assert property (updown_count == comp_pwm_on) else $error("count direction");
  a_pin_off: assert property ((pin_out & ~pin_timer_sel & $past(timer_oe)) == 6'h00) else $error("pin leak");
  a_pin_pair: assert property ((pin_out & $past(timer_oe)) == (pin_timer_sel & $past(timer_out)))
    else $error("pin output mismatch");
  a_sb_func: assert property (standby_entry |-> ##2 buffer_on == 4'h0 && !comp_pwm_on && !rsync_pwm_on)
    else $error("standby func reload");
  a_sb_enable: assert property (standby_entry |-> ##2 pin_timer_sel == $past(timer_oe))
    else $error("standby enable reload");
  c_write: cover property (wr_f);
  c_comp: cover property (comp_pwm_on);
  c_rsync: cover property (rsync_pwm_on);
  c_pins_off: cover property (pin_timer_sel == 6'h00);
endmodule : ppg_top_sva
bind ppg_top ppg_top_sva u_ppg_top_sva (.*);

// ### sim/ppg_drive_stage.sv
`timescale 1ns/1ps
module ppg_drive_stage (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_timer_sel,
  output logic      [5:0] pin_level
);
  // Released pins sit at the pull-up level
  assign pin_level = (pin_out & pin_timer_sel) | ~pin_timer_sel;
endmodule : ppg_drive_stage

// ### sim/paired_pwm_mode_and_output_gate_test.sv
`timescale 1ns/1ps
module paired_pwm_mode_and_output_gate_test;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        standby_entry = 1'b0, ch1_capture_a = 1'b0, cap = 1'b0, err;
  logic        ch3_pulse_width_select = 1'b1, ch4_pulse_width_select = 1'b1;
  logic        ch3_sync_select = 1'b1, ch4_sync_select = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0]  timer_out = 6'h2d, timer_oe = 6'h3b, pin_out, pin_timer_sel, pin_level, m;
  logic        pready, pslverr, ch3_pwm_eff, ch4_pwm_eff, ch3_sync_eff, ch4_sync_eff;
  logic        comp_pwm_on, rsync_pwm_on, updown_count;
  logic [3:0]  buffer_on;
  int          n_fail = 0, n_checks = 0;
  ppg_top u_ppg_top (.*);
  ppg_drive_stage u_ppg_drive_stage (.*);
  initial forever #4 pclk = ~pclk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ch1_capture_a <= cap;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ch1_capture_a <= 1'b0;
  endtask : xfer
  task automatic rdchk(string nm, logic [11:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  task automatic pulse(logic sb);
    @(posedge pclk);
    if (sb) standby_entry <= 1'b1;
    else ch1_capture_a <= 1'b1;
    @(posedge pclk);
    standby_entry <= 1'b0;
    ch1_capture_a <= 1'b0;
  endtask : pulse
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (4000) @(posedge pclk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("func", 12'h000, 32'hc0);
    rdchk("oe", 12'h004, 32'hff);
    rdchk("aux", 12'h008, 32'h01);
    xfer(1'b1, 12'h000, 32'h0);
    rdchk("func rsvd", 12'h000, 32'hc0);
    xfer(1'b1, 12'h004, 32'h0);
    rdchk("oe rsvd", 12'h004, 32'hc0);
    xfer(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 6; i++) begin
      m = 6'(1 << i);
      xfer(1'b1, 12'h004, 32'(1 << i));
      repeat (3) @(negedge pclk);
      chk("pins", {14'h0, m & timer_oe, m & timer_out, ~(m & timer_oe) | timer_out},
        {14'h0, pin_timer_sel, pin_out, pin_level});
    end
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 12'h000, {26'h0, 2'(k), 4'(1 << k)});
      repeat (3) @(negedge pclk);
      chk("mode", {21'h0, k == 2, k == 3, k == 2, k < 2, k < 2, 2'b10, 4'(1 << k)}, {21'h0, comp_pwm_on,
        rsync_pwm_on, updown_count, ch3_pwm_eff, ch4_pwm_eff, ch3_sync_eff, ch4_sync_eff, buffer_on});
    end
    xfer(1'b1, 12'h004, 32'hff);
    pulse(1'b0);
    rdchk("blocked", 12'h004, 32'hff);
    xfer(1'b1, 12'h008, 32'h0);
    pulse(1'b0);
    rdchk("trig", 12'h004, 32'hc0);
    rdchk("trig flag", 12'h00c, 32'h9);
    xfer(1'b1, 12'h00c, 32'h1);
    rdchk("flag clr", 12'h00c, 32'h8);
    xfer(1'b1, 12'h000, 32'h0);
    xfer(1'b1, 12'h004, 32'hff);
    pulse(1'b0);
    rdchk("normal", 12'h004, 32'hff);
    xfer(1'b1, 12'h000, 32'h20);
    cap = 1'b1;
    xfer(1'b1, 12'h004, 32'hff);
    cap = 1'b0;
    rdchk("clash", 12'h004, 32'hc0);
    rdchk("clash flag", 12'h00c, 32'hd);
    xfer(1'b1, 12'h000, 32'h3f);
    pulse(1'b1);
    rdchk("sb func", 12'h000, 32'hc0);
    rdchk("sb oe", 12'h004, 32'hff);
    rdchk("sb aux", 12'h008, 32'h01);
    stop_test();
  end
endmodule : paired_pwm_mode_and_output_gate_test
